// ==== logic/sfh_ctrl.v ====
// Host controller that drives a serial flash through its select, clock and data pins
//
// What this block does
// - Page-size configuration sends select low, then 3D,2A,80,A6 exactly in order.
// - Select released right after the last configuration bit starts programming.
// - Status bit 0 (binary page size) is only passed to software; the block neither checks it nor reissues.
// - Identification read sends 9F then clocks in bytes, MSB first.
// - Extended length byte is zero; host may skip reading it.
// - Releasing select ends identification read at any point.
// - Host treats up to MAX_CONT (default 4) leading 7F bytes as continuation and keeps reading.
// - Host starts nothing while a read-group command is running.
// - Buffer and query commands are allowed during self-timed array operations.
// - Host uses the opposite buffer to the running array command.
// - During protection programming the host issues only status reads.
// - Status read sends D7; status byte repeats while clocking continues.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sfh_map.vh"
module sfh_ctrl #(
	parameter DIV_HALF = `SFH_DIV_HALF,
	parameter MAX_CONT = 4
) (
	input wire clk_sys,
	input wire srst,
	input wire [3:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWr,
	input wire regRd,
	output reg [31:0] regRdata,
	output reg flashSelN,
	output reg flashClk,
	output reg flashDout,
	input wire flashDin
);
////////////////////////////////////////////////////////////////////////
// Pin input synchroniser
reg dinMeta_q;
reg dinSync_q;
always @(posedge clk_sys) begin
	dinMeta_q <= flashDin;
	dinSync_q <= dinMeta_q;
end
////////////////////////////////////////////////////////////////////////
// Sequencer states
localparam S_IDLE = 3'd0;
localparam S_SEL = 3'd1;
localparam S_LOW = 3'd2;
localparam S_HIGH = 3'd3;
localparam S_END = 3'd4;
reg [2:0] state_q;
reg [7:0] div_q;
reg [7:0] txShift_q;
reg [7:0] rxShift_q;
reg [2:0] bitCnt_q;
reg [2:0] txByte_q;
reg [2:0] txLen_q;
reg [2:0] rxByte_q;
reg [2:0] rxLen_q;
reg [1:0] op_q;
reg busy_q;
reg [7:0] status_q;
reg [7:0] mfr_q;
reg [7:0] dev1_q;
reg [7:0] dev2_q;
reg [7:0] xlen_q;
reg [2:0] contCnt_q;
reg done_q;
reg cfgFail_q;
wire tick = (div_q == DIV_HALF[7:0] - 8'h01);
// Command bytes in order; the configuration bytes are never split across frames
function [7:0] cmdByte;
	input [1:0] op;
	input [2:0] idx;
	begin
		cmdByte = `SFH_OC_STATUS;
		if (op == `SFH_OP_ID)
			cmdByte = `SFH_OC_ID;
		else if (op == `SFH_OP_CFG) begin
			case (idx)
				3'd0: cmdByte = `SFH_OC_CFG0;
				3'd1: cmdByte = `SFH_OC_CFG1;
				3'd2: cmdByte = `SFH_OC_CFG2;
				default: cmdByte = `SFH_OC_CFG3;
			endcase
		end
	end
endfunction
wire [7:0] nextCmd = cmdByte(op_q, txByte_q + 3'd1);
////////////////////////////////////////////////////////////////////////
// Serial engine, mode 0: data set while clock low, sampled on rising edge
always @(posedge clk_sys) begin
	if (srst) begin
		state_q <= S_IDLE;
		div_q <= 8'h00;
		txShift_q <= 8'h00;
		rxShift_q <= 8'h00;
		bitCnt_q <= 3'd0;
		txByte_q <= 3'd0;
		txLen_q <= 3'd0;
		rxByte_q <= 3'd0;
		rxLen_q <= 3'd0;
		op_q <= 2'h0;
		busy_q <= 1'b0;
		status_q <= 8'h00;
		mfr_q <= 8'h00;
		dev1_q <= 8'h00;
		dev2_q <= 8'h00;
		xlen_q <= 8'h00;
		contCnt_q <= 3'd0;
		done_q <= 1'b0;
		cfgFail_q <= 1'b0;
		flashSelN <= 1'b1;
		flashClk <= 1'b0;
		flashDout <= 1'b0;
	end else begin
		div_q <= tick ? 8'h00 : div_q + 8'h01;
		case (state_q)
			S_IDLE: begin
				// A single frame at a time keeps any command from overlapping another
				// No overlap is ever issued, so buffer choice and protection phases cannot clash
				if (regWr && regAddr == `SFH_ADDR_CTRL && regWdata[`SFH_CTRL_GO]) begin
					op_q <= regWdata[`SFH_CTRL_OP_HI:`SFH_CTRL_OP_LO];
					busy_q <= 1'b1;
					done_q <= 1'b0;
					txByte_q <= 3'd0;
					rxByte_q <= 3'd0;
					contCnt_q <= 3'd0;
					txLen_q <= (regWdata[`SFH_CTRL_OP_HI:`SFH_CTRL_OP_LO] == `SFH_OP_CFG) ? 3'd4 : 3'd1;
					// Identification reads four bytes; status reads one repeat
					rxLen_q <= (regWdata[`SFH_CTRL_OP_HI:`SFH_CTRL_OP_LO] == `SFH_OP_ID) ? 3'd4 :
						(regWdata[`SFH_CTRL_OP_HI:`SFH_CTRL_OP_LO] == `SFH_OP_STATUS) ? 3'd1 : 3'd0;
					txShift_q <= cmdByte(regWdata[`SFH_CTRL_OP_HI:`SFH_CTRL_OP_LO], 3'd0);
					bitCnt_q <= 3'd0;
					state_q <= S_SEL;
				end
			end
			S_SEL: if (tick) begin
				flashSelN <= 1'b0;
				flashDout <= txShift_q[7];
				state_q <= S_LOW;
			end
			S_LOW: if (tick) begin
				flashClk <= 1'b1;
				if (txByte_q >= txLen_q)
					rxShift_q <= {rxShift_q[6:0], dinSync_q};
				state_q <= S_HIGH;
			end
			S_HIGH: if (tick) begin
				flashClk <= 1'b0;
				bitCnt_q <= bitCnt_q + 3'd1;
				state_q <= S_LOW;
				if (txByte_q < txLen_q) begin
					txShift_q <= {txShift_q[6:0], 1'b0};
					flashDout <= txShift_q[6];
					if (bitCnt_q == 3'd7) begin
						txByte_q <= txByte_q + 3'd1;
						txShift_q <= nextCmd;
						flashDout <= nextCmd[7];
						// Select rises right after the last configuration bit
						if (txByte_q + 3'd1 == txLen_q && rxLen_q == 3'd0)
							state_q <= S_END;
					end
				end else if (bitCnt_q == 3'd7) begin
					flashDout <= 1'b0;
					if (op_q == `SFH_OP_STATUS) begin
						status_q <= rxShift_q;
						state_q <= S_END;
					end else if (rxByte_q == 3'd0 && rxShift_q == `SFH_CONT_CODE && contCnt_q < MAX_CONT[2:0]) begin
						contCnt_q <= contCnt_q + 3'd1;
					end else begin
						rxByte_q <= rxByte_q + 3'd1;
						case (rxByte_q)
							3'd0: mfr_q <= rxShift_q;
							3'd1: dev1_q <= rxShift_q;
							3'd2: dev2_q <= rxShift_q;
							default: xlen_q <= rxShift_q;
						endcase
						if (rxByte_q + 3'd1 == rxLen_q)
							state_q <= S_END;
					end
				end else begin
					flashDout <= 1'b0;
				end
			end
			S_END: if (tick) begin
				flashSelN <= 1'b1;
				flashClk <= 1'b0;
				busy_q <= 1'b0;
				done_q <= 1'b1;
				// The device ignores an incomplete sequence, so flag one here
				cfgFail_q <= (op_q == `SFH_OP_CFG) && (txByte_q != 3'd4);
				state_q <= S_IDLE;
			end
			default: state_q <= S_IDLE;
		endcase
	end
end
////////////////////////////////////////////////////////////////////////
// Register read port; status bits let software poll ready and page size
always @(posedge clk_sys) begin
	if (srst) begin
		regRdata <= `SFH_ID_RESET;
	end else if (regRd) begin
		case (regAddr)
			`SFH_ADDR_CTRL: regRdata <= {29'h0, op_q, busy_q};
			`SFH_ADDR_STAT: regRdata <= {16'h0, cfgFail_q, done_q, busy_q, 3'h0, status_q[`SFH_ST_READY],
				status_q[`SFH_ST_PAGE512], status_q};
			`SFH_ADDR_ID: regRdata <= {mfr_q, dev1_q, dev2_q, 5'h0, contCnt_q};
			`SFH_ADDR_XLEN: regRdata <= {24'h0, xlen_q};
			default: regRdata <= 32'h00000000;
		endcase
	end else begin
		regRdata <= 32'h00000000;
	end
end
endmodule // sfh_ctrl
`default_nettype wire

// ==== logic/sfh_map.vh ====
// Constants for the serial flash host controller
`ifndef SFH_MAP_VH
`define SFH_MAP_VH
`define SFH_ADDR_CTRL 4'h0
`define SFH_ADDR_STAT 4'h1
`define SFH_ADDR_ID 4'h2
`define SFH_ADDR_XLEN 4'h3
`define SFH_CTRL_GO 0
`define SFH_CTRL_OP_LO 1
`define SFH_CTRL_OP_HI 2
`define SFH_OP_CFG 2'h0
`define SFH_OP_ID 2'h1
`define SFH_OP_STATUS 2'h2
`define SFH_OC_CFG0 8'h3d
`define SFH_OC_CFG1 8'h2a
`define SFH_OC_CFG2 8'h80
`define SFH_OC_CFG3 8'ha6
`define SFH_OC_ID 8'h9f
`define SFH_OC_STATUS 8'hd7
`define SFH_CONT_CODE 8'h7f
`define SFH_ST_READY 7
`define SFH_ST_PAGE512 0
`define SFH_DIV_HALF 4
`define SFH_ID_RESET 32'h00000000
`endif

// ==== bench/sfh_ctrl_properties.sv ====
// Port checker for the serial flash host controller
`timescale 1ns/1ps
`default_nettype none
module sfh_ctrl_checker #(parameter DIV_HALF = 4) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic [3:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [31:0] regRdata,
	input wire logic flashSelN,
	input wire logic flashClk,
	input wire logic flashDout,
	input wire logic flashDin
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	logic [5:0] bitCnt_q;
	int halfCnt_q;
	always_ff @(posedge clk_sys) begin
		bitCnt_q <= flashSelN ? 6'h0 : bitCnt_q + 6'($rose(flashClk));
		halfCnt_q <= $changed(flashClk) ? 0 : halfCnt_q + 1;
	end
	////////////////////////////////////////////////////////////////
	reset_idle_a: assert property (disable iff (1'b0) srst |=> flashSelN && !flashClk) else $error("not idle");
	idle_low_a: assert property (flashSelN |-> !flashClk) else $error("clock off frame");
	read_zero_a: assert property (!$past(regRd) |-> regRdata == 32'h0) else $error("stray read data");
	half_bit_a: assert property ($fell(flashClk) |-> halfCnt_q == DIV_HALF - 1) else $error("bad half bit");
	dout_hold_a: assert property ($rose(flashClk) |-> $stable(flashDout)) else $error("data moved");
	sel_first_a: assert property ($fell(flashSelN) |-> !flashClk [*2]) else $error("early clock");
	go_start_a: assert property (regWr && regAddr == 4'h0 && regWdata[0] && flashSelN |-> ##[1:12] !flashSelN)
		else $error("no frame");
	// A frame that is one bit short is ignored by the device, leaving the page size unchanged
	frame_len_a: assert property ($rose(flashSelN) |-> bitCnt_q inside {6'd16, 6'd32, 6'd40})
		else $error("frame length");
	cfg_c: cover property ($rose(flashSelN) && bitCnt_q == 6'd32);
	id_c: cover property ($rose(flashSelN) && bitCnt_q == 6'd40);
	stat_c: cover property ($rose(flashSelN) && bitCnt_q == 6'd16);
endmodule // sfh_ctrl_checker
bind sfh_ctrl sfh_ctrl_checker #(.DIV_HALF(DIV_HALF)) sfh_ctrl_checker_inst (.clk_sys(clk_sys), .srst(srst),
	.regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
	.flashSelN(flashSelN), .flashClk(flashClk), .flashDout(flashDout), .flashDin(flashDin));
`default_nettype wire

// ==== bench/sfh_flash_model.sv ====
// Behavioural serial flash for the host controller bench
`timescale 1ns/1ps
`default_nettype none
module sfh_flash_model #(
	parameter [7:0] MFR = 8'h5a, // Arbitrary value
	parameter [15:0] DEV = 16'h4321, // Arbitrary value
	parameter int TP_NS = 20000
) (
	input wire logic selN,
	input wire logic sck,
	input wire logic si,
	output logic so
);
	logic [31:0] inR, outR;
	realtime busyEnd = 0;
	int cnt;
	initial so = 0;
	always @(negedge selN) cnt = 0;
	always @(posedge sck) if (!selN) begin
		inR = {inR[30:0], si};
		cnt++;
		// Page bit stays 528 until a power cycle, which is not modelled
		if (cnt == 8) outR = (inR[7:0] == 8'h9f) ? {MFR, DEV, 8'h00} : {4{($realtime >= busyEnd), 7'h2c}};
	end
	always @(negedge sck) if (!selN && cnt >= 8) begin
		so = outR[31];
		outR = {outR[30:0], outR[31]};
	end
	always @(posedge selN) begin
		so = ~so;
		// A time stamp rather than a delay, so later frames are never missed
		if (cnt == 32 && inR == 32'h3d2a80a6) busyEnd = $realtime + TP_NS;
	end
endmodule // sfh_flash_model
`default_nettype wire

// ==== bench/sfh_ctrl_bench.sv ====
// Testbench for the serial flash host controller
`timescale 1ns/1ps
`default_nettype none
module sfh_ctrl_bench;
	logic clk_sys = 0, srst = 1, regWr = 0, regRd = 0, selN, sck, mosi, miso;
	logic [3:0] regAddr = 0;
	logic [31:0] regWdata = 0, regRdata, d;
	int n_fail = 0, compares = 0;
	always #20 clk_sys = ~clk_sys;
	sfh_ctrl sfh_ctrl_inst (.clk_sys(clk_sys), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
		.regRd(regRd), .regRdata(regRdata), .flashSelN(selN), .flashClk(sck), .flashDout(mosi), .flashDin(miso));
	sfh_flash_model sfh_flash_model_inst (.selN(selN), .sck(sck), .si(mosi), .so(miso));
	task chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk_sys);
		regAddr <= a;
		regRd <= 1;
		@(posedge clk_sys);
		regRd <= 0;
		#1 d = regRdata;
	endtask
	task run(input logic [1:0] op);
		@(posedge clk_sys);
		regAddr <= 4'h0;
		regWdata <= {29'h0, op, 1'b1};
		regWr <= 1;
		@(posedge clk_sys);
		regWr <= 0;
		repeat (5) @(posedge clk_sys);
		rd(4'h1);
		for (int i = 0; i < 2000 && d[13]; i++) rd(4'h1);
		chk(d & 32'h2000, 32'h0);
	endtask
	task t_id;
		run(2'h1);
		rd(4'h2);
		chk(d, 32'h5a432100);
		rd(4'h3);
		chk(d, 32'h0);
		rd(4'hf);
		chk(d, 32'h0);
		rd(4'h0);
		chk(d, 32'h2);
		$display("id test done");
	endtask
	task t_cfg;
		run(2'h0);
		run(2'h2);
		chk(d & 32'hffff, 32'h402c);
		repeat (600) @(posedge clk_sys);
		run(2'h2);
		chk(d & 32'hffff, 32'h42ac);
		$display("config test done");
	endtask
	task finish_test;
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_sys);
		srst <= 0;
		t_id;
		t_cfg;
		finish_test;
	end
	initial begin
		#2000000;
		n_fail++;
		finish_test;
	end
endmodule // sfh_ctrl_bench
`default_nettype wire
